// ### stm_top.sv
// split timer: registers, wide counter, rtc, interrupts and two halves
`timescale 1ns/1ps
// Notes on behaviour
// - a mode configuration write clears both run enables; they stay clear until a control write
// - joined 32-bit one-shot, periodic or rtc counting, or two split halves
// - half A: one-shot, periodic, edge count, edge time or pwm, 16 bits
// - half B offers the same five modes from its own field
// - polarity set makes the pwm output active low, clear active high
// - debug halt select stops a half while the processor is in debug
// - each half's trigger output can be enabled or disabled
// - run enables for half A, half B, or both in one write
// - a clear mask resets the selected pending sources only
// - only enabled pending sources drive the interrupt line
// - disable mask clears selected enables; all masks share one layout
// - sources: capture event, capture match, timeout per half, rtc match
// - raw and masked pending status are both readable
// - one-shot stops at zero; periodic reloads and keeps counting
module stm_top #(
    parameter int RTC_DIV = stm_pkg::RTC_DIV_DEF
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        dbg_halt,
    input  wire logic        rtc_clk_in,
    input  wire logic        ccp_a_i,
    output logic             ccp_a_o,
    output logic             ccp_a_oe,
    input  wire logic        ccp_b_i,
    output logic             ccp_b_o,
    output logic             ccp_b_oe,
    output logic             trig_a,
    output logic             trig_b,
    output logic             irq
);
    stm_pkg::stm_top_t q;
    stm_pkg::stm_top_t d;
    logic [6:0]        clr;
    logic [6:0]        ev;
    logic              wtmo;
    logic              tick;
    logic              split;
    logic              rtc;
    logic              wen;
    logic              wrun;
    logic [31:0]       wload;
    logic [31:0]       wmatch;
    logic [1:0]        ccp_i;
    logic [1:0]        tmo_v;
    logic [1:0]        cev_v;
    logic [1:0]        cmt_v;
    logic [1:0]        pwm_v;
    logic [1:0]        oe_v;
    logic [1:0][15:0]  val_v;

    assign split  = q.wmode == stm_pkg::split_pair_mode;
    assign rtc    = q.wmode == stm_pkg::wide_rtc_mode;
    assign wen    = q.ctl[stm_pkg::CTL_RUN_LSB] && !split;
    assign wrun   = wen && !(q.ctl[stm_pkg::debug_halt_select_lsb]
                             && dbg_halt);
    assign wload  = {q.load[1], q.load[0]};
    assign wmatch = {q.match[1], q.match[0]};
    assign ccp_i  = {ccp_b_i, ccp_a_i};

    // ****************************************
    // halves
    // ****************************************
    stm_half_if hif[2] ();

    for (genvar g = 0; g < 2; g++) begin : g_half
        assign hif[g].mode     = q.hmode[g];
        assign hif[g].load     = q.load[g];
        assign hif[g].match    = q.match[g];
        assign hif[g].en       = q.ctl[stm_pkg::CTL_RUN_LSB + g]
                                 && split;
        assign hif[g].run      = hif[g].en
            && !(q.ctl[stm_pkg::debug_halt_select_lsb + g]
                 && dbg_halt);
        assign hif[g].pol      = q.ctl[stm_pkg::CTL_POL_LSB + g];
        assign hif[g].pin_edge = q.cs[g][1] && !q.cs[g][2];
        assign tmo_v[g]        = hif[g].tmo;
        assign cev_v[g]        = hif[g].cev;
        assign cmt_v[g]        = hif[g].cmt;
        assign pwm_v[g]        = hif[g].pwm;
        assign oe_v[g]         = split
            && q.hmode[g] == stm_pkg::half_pwm_mode;
        assign val_v[g]        =
            q.hmode[g] == stm_pkg::edge_time_capture_mode
            ? hif[g].cap : hif[g].cnt;

        stm_half u_half (
            .sys_clk (sys_clk),
            .sys_rst (sys_rst),
            .h       (hif[g].half)
        );
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d       = q;
        clr     = '0;
        ev      = '0;
        wtmo    = 1'b0;
        tick    = 1'b0;
        d.rdata = '0;
        for (int g = 0; g < 2; g++) begin
            d.cs[g] = {q.cs[g][1:0], ccp_i[g]};
        end
        d.rs = {q.rs[1:0], rtc_clk_in};

        // rtc prescaler: external edges down to one tick
        if (q.rs[1] && !q.rs[2] && rtc && wen) begin
            if (q.div == 16'(RTC_DIV - 1)) begin
                d.div = '0;
                tick  = 1'b1;
            end else begin
                d.div = q.div + 16'h0001;
            end
        end

        // joined 32-bit counter
        case (q.wst)
            stm_pkg::HS_ARM: begin
                d.wcnt = rtc ? 32'h0000_0000 : wload;
                if (wen) begin
                    d.wst = stm_pkg::HS_RUN;
                end
            end
            stm_pkg::HS_RUN: begin
                if (!wen) begin
                    d.wst = stm_pkg::HS_ARM;
                end else if (rtc) begin
                    if (tick) begin
                        d.wcnt = q.wcnt + 32'h0000_0001;
                        if (d.wcnt == wmatch) begin
                            ev[stm_pkg::IRQ_RTC] = 1'b1;
                        end
                    end
                end else if (wrun) begin
                    if (q.wcnt == 32'h0000_0000) begin
                        wtmo = 1'b1;
                        if (q.wmode == stm_pkg::wide_one_shot_mode) begin
                            d.wst = stm_pkg::HS_DONE;
                        end else begin
                            d.wcnt = wload;
                        end
                    end else begin
                        d.wcnt = q.wcnt - 32'h0000_0001;
                    end
                end
            end
            stm_pkg::HS_DONE: begin
                if (!wen) begin
                    d.wst = stm_pkg::HS_ARM;
                end
            end
            default: d.wst = stm_pkg::HS_ARM;
        endcase

        // event collection and triggers
        for (int g = 0; g < 2; g++) begin
            ev[g * stm_pkg::IRQ_STEP + stm_pkg::IRQ_TMO] =
                tmo_v[g] || (g == 0 && wtmo);
            ev[g * stm_pkg::IRQ_STEP + stm_pkg::IRQ_CMT] = cmt_v[g];
            ev[g * stm_pkg::IRQ_STEP + stm_pkg::IRQ_CEV] = cev_v[g];
            d.trg[g] = q.ctl[stm_pkg::trigger_out_enable_lsb + g]
                && ev[g * stm_pkg::IRQ_STEP + stm_pkg::IRQ_TMO];
        end

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                stm_pkg::A_CFG: begin
                    d.wmode    = reg_wdata[stm_pkg::CFG_W_LSB +: 3];
                    d.hmode[0] = reg_wdata[stm_pkg::CFG_A_LSB +: 3];
                    d.hmode[1] = reg_wdata[stm_pkg::CFG_B_LSB +: 3];
                    d.ctl[stm_pkg::CTL_RUN_LSB +: 2] = 2'b00;
                end
                stm_pkg::A_CTL:     d.ctl = reg_wdata[7:0];
                stm_pkg::A_LOAD_A:  d.load[0] = reg_wdata[15:0];
                stm_pkg::A_LOAD_B:  d.load[1] = reg_wdata[15:0];
                stm_pkg::A_MATCH_A: d.match[0] = reg_wdata[15:0];
                stm_pkg::A_MATCH_B: d.match[1] = reg_wdata[15:0];
                stm_pkg::A_IEN:
                    d.ien = q.ien | reg_wdata[6:0];
                stm_pkg::A_IDIS:
                    d.ien = q.ien & ~reg_wdata[6:0];
                stm_pkg::A_ICLR:    clr = reg_wdata[6:0];
                default: ;
            endcase
        end
        d.ris = (q.ris & ~clr) | ev;

        // register reads, data in the following cycle only
        if (reg_rd) begin
            case (reg_addr)
                stm_pkg::A_CFG: d.rdata = {21'h000000, q.hmode[1], 1'b0,
                                           q.hmode[0], 1'b0, q.wmode};
                stm_pkg::A_CTL:     d.rdata = {24'h000000, q.ctl};
                stm_pkg::A_LOAD_A:  d.rdata = {16'h0000, q.load[0]};
                stm_pkg::A_LOAD_B:  d.rdata = {16'h0000, q.load[1]};
                stm_pkg::A_MATCH_A: d.rdata = {16'h0000, q.match[0]};
                stm_pkg::A_MATCH_B: d.rdata = {16'h0000, q.match[1]};
                stm_pkg::A_VAL_A:
                    d.rdata = split ? {16'h0000, val_v[0]} : q.wcnt;
                stm_pkg::A_VAL_B:
                    d.rdata = split ? {16'h0000, val_v[1]}
                                    : {16'h0000, q.wcnt[31:16]};
                stm_pkg::A_IEN:     d.rdata = {25'h0000000, q.ien};
                stm_pkg::A_RIS:     d.rdata = {25'h0000000, q.ris};
                stm_pkg::A_MIS:
                    d.rdata = {25'h0000000, q.ris & q.ien};
                default:            d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q <= stm_pkg::TOP_RST;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata = q.rdata;
    assign irq       = |(q.ris & q.ien);
    assign trig_a    = q.trg[0];
    assign trig_b    = q.trg[1];
    assign ccp_a_o   = pwm_v[0];
    assign ccp_b_o   = pwm_v[1];
    assign ccp_a_oe  = oe_v[0];
    assign ccp_b_oe  = oe_v[1];

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_cfg_wr;
        reg_wr && reg_addr == stm_pkg::A_CFG;
    endsequence
    sequence s_no_ctl_wr;
        !(reg_wr && reg_addr == stm_pkg::A_CTL);
    endsequence

    chk_cfg_disable: assert property (
        s_cfg_wr ##1 s_no_ctl_wr |=> q.ctl[1:0] == 2'b00)
        else $error("run enables not clear after configuration");
    chk_clear_mask: assert property (
        reg_wr && reg_addr == stm_pkg::A_ICLR && reg_wdata[0] && !ev[0]
        |=> !q.ris[0])
        else $error("selected source not cleared");
    chk_clear_keep: assert property (
        reg_wr && reg_addr == stm_pkg::A_ICLR && !reg_wdata[1]
        && q.ris[1] |=> q.ris[1])
        else $error("unselected source was cleared");
    chk_irq_gate: assert property (
        reg_wr && reg_addr == stm_pkg::A_IDIS && reg_wdata[6:0] == 7'h7F
        |=> !irq)
        else $error("interrupt with all sources disabled");
    chk_dis_keep: assert property (
        reg_wr && reg_addr == stm_pkg::A_IDIS && !reg_wdata[2]
        && q.ien[2] |=> q.ien[2])
        else $error("unselected enable was cleared");
    chk_trig_gate: assert property (
        ev[0] && !q.ctl[stm_pkg::trigger_out_enable_lsb] |=> !trig_a)
        else $error("trigger with trigger disabled");
    chk_wide_reload: assert property (
        q.wst == stm_pkg::HS_RUN && wrun && !rtc && q.wcnt == 32'h0
        && q.wmode == stm_pkg::wide_periodic_mode
        |=> q.wcnt == $past(wload) ##1 q.wst == stm_pkg::HS_RUN)
        else $error("wide periodic counter did not reload");

    sequence s_ctl_wr;
        reg_wr && reg_addr == stm_pkg::A_CTL;
    endsequence

    chk_half_enable: assert property (
        s_ctl_wr ##0 split
        |=> hif[0].en == $past(reg_wdata[stm_pkg::CTL_RUN_LSB])
        && hif[1].en == $past(reg_wdata[stm_pkg::CTL_RUN_LSB + 1]))
        else $error("half run enables do not follow the write");
    chk_trig_pulse: assert property (
        ev[0] && q.ctl[stm_pkg::trigger_out_enable_lsb] |=> trig_a)
        else $error("enabled trigger did not pulse");
    chk_raw_read: assert property (
        reg_rd && reg_addr == stm_pkg::A_RIS
        |=> reg_rdata == {25'h0000000, $past(q.ris)})
        else $error("raw status read wrong");
    chk_masked_read: assert property (
        reg_rd && reg_addr == stm_pkg::A_MIS
        |=> reg_rdata == {25'h0000000, $past(q.ris) & $past(q.ien)})
        else $error("masked status read wrong");
endmodule

// ### stm_pkg.sv
// split timer package: register map, field layout, codes and state types
package stm_pkg;
    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] A_CFG     = 8'h00;
    localparam logic [7:0] A_CTL     = 8'h04;
    localparam logic [7:0] A_LOAD_A  = 8'h08;
    localparam logic [7:0] A_LOAD_B  = 8'h0C;
    localparam logic [7:0] A_MATCH_A = 8'h10;
    localparam logic [7:0] A_MATCH_B = 8'h14;
    localparam logic [7:0] A_VAL_A   = 8'h18;
    localparam logic [7:0] A_VAL_B   = 8'h1C;
    localparam logic [7:0] A_IEN     = 8'h20;
    localparam logic [7:0] A_IDIS    = 8'h24;
    localparam logic [7:0] A_RIS     = 8'h28;
    localparam logic [7:0] A_MIS     = 8'h2C;
    localparam logic [7:0] A_ICLR    = 8'h30;
    // ****************************************
    // field positions
    // ****************************************
    localparam int CFG_W_LSB             = 0;
    localparam int CFG_A_LSB             = 4;
    localparam int CFG_B_LSB             = 8;
    localparam int CTL_RUN_LSB           = 0;
    localparam int CTL_POL_LSB           = 2;
    localparam int debug_halt_select_lsb = 4;
    localparam int trigger_out_enable_lsb = 6;
    localparam int IRQ_N    = 7;
    localparam int IRQ_TMO  = 0;
    localparam int IRQ_CMT  = 1;
    localparam int IRQ_CEV  = 2;
    localparam int IRQ_RTC  = 3;
    localparam int IRQ_STEP = 4;
    localparam int RTC_DIV_DEF = 32768;
    // ****************************************
    // mode codes
    // ****************************************
    localparam logic [2:0] wide_one_shot_mode     = 3'h0;
    localparam logic [2:0] wide_periodic_mode     = 3'h1;
    localparam logic [2:0] wide_rtc_mode          = 3'h2;
    localparam logic [2:0] split_pair_mode        = 3'h4;
    localparam logic [2:0] half_one_shot_mode     = 3'h0;
    localparam logic [2:0] half_periodic_mode     = 3'h1;
    localparam logic [2:0] edge_count_capture_mode = 3'h2;
    localparam logic [2:0] edge_time_capture_mode = 3'h3;
    localparam logic [2:0] half_pwm_mode          = 3'h4;
    // ****************************************
    // state types
    // ****************************************
    typedef enum logic [2:0] {
        HS_ARM  = 3'b001,
        HS_RUN  = 3'b010,
        HS_DONE = 3'b100
    } stm_hst_t;
    typedef struct packed {
        stm_hst_t    st;
        logic [15:0] cnt;
        logic [15:0] cap;
        logic        tmo;
        logic        cev;
        logic        cmt;
        logic        pwm;
    } stm_half_t;
    typedef struct packed {
        logic [2:0]       wmode;
        logic [1:0][2:0]  hmode;
        logic [7:0]       ctl;
        logic [1:0][15:0] load;
        logic [1:0][15:0] match;
        stm_hst_t         wst;
        logic [31:0]      wcnt;
        logic [15:0]      div;
        logic [6:0]       ien;
        logic [6:0]       ris;
        logic [1:0]       trg;
        logic [1:0][2:0]  cs;
        logic [2:0]       rs;
        logic [31:0]      rdata;
    } stm_top_t;
    localparam stm_half_t HALF_RST = '{st: HS_ARM, default: '0};
    localparam stm_top_t  TOP_RST  = '{wst: HS_ARM, default: '0};
endpackage

// ### stm_half_if.sv
// split timer: link between the control block and one 16-bit half
`timescale 1ns/1ps
interface stm_half_if;
    logic [2:0]  mode;
    logic [15:0] load;
    logic [15:0] match;
    logic        en;
    logic        run;
    logic        pol;
    logic        pin_edge;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic        tmo;
    logic        cev;
    logic        cmt;
    logic        pwm;
    modport ctl  (output mode, load, match, en, run, pol, pin_edge,
                  input cnt, cap, tmo, cev, cmt, pwm);
    modport half (input mode, load, match, en, run, pol, pin_edge,
                  output cnt, cap, tmo, cev, cmt, pwm);
endinterface

// ### stm_half.sv
// split timer: one 16-bit half with timer, capture and pwm modes
`timescale 1ns/1ps
module stm_half (
    input wire logic  sys_clk,
    input wire logic  sys_rst,
    stm_half_if.half  h
);
    stm_pkg::stm_half_t q;
    stm_pkg::stm_half_t d;
    logic               zero;
    logic               live;

    assign zero = q.cnt == 16'h0000;
    assign live = q.st == stm_pkg::HS_RUN && h.en;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d = q;
        d.tmo = 1'b0;
        d.cev = 1'b0;
        d.cmt = 1'b0;
        case (q.st)
            stm_pkg::HS_ARM: begin
                d.cnt = h.load;
                if (h.en) begin
                    d.st = stm_pkg::HS_RUN;
                end
            end
            stm_pkg::HS_RUN: begin
                if (!h.en) begin
                    d.st = stm_pkg::HS_ARM;
                end else if (h.run) begin
                    case (h.mode)
                        stm_pkg::edge_count_capture_mode: begin
                            if (h.pin_edge && q.cnt == h.match) begin
                                d.cmt = 1'b1;
                                d.cnt = h.load;
                            end else if (h.pin_edge) begin
                                d.cnt = q.cnt - 16'h0001;
                            end
                        end
                        stm_pkg::edge_time_capture_mode: begin
                            d.cnt = q.cnt - 16'h0001;
                            if (h.pin_edge) begin
                                d.cap = q.cnt;
                                d.cev = 1'b1;
                            end
                        end
                        default: begin
                            if (zero) begin
                                d.tmo = 1'b1;
                                if (h.mode == stm_pkg::half_one_shot_mode) begin
                                    d.st = stm_pkg::HS_DONE;
                                end else begin
                                    d.cnt = h.load;
                                end
                            end else begin
                                d.cnt = q.cnt - 16'h0001;
                            end
                        end
                    endcase
                end
            end
            stm_pkg::HS_DONE: begin
                if (!h.en) begin
                    d.st = stm_pkg::HS_ARM;
                end
            end
            default: d.st = stm_pkg::HS_ARM;
        endcase
        d.pwm = (h.mode == stm_pkg::half_pwm_mode && live
                 && q.cnt > h.match) ^ h.pol;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q <= stm_pkg::HALF_RST;
        end else begin
            q <= d;
        end
    end

    assign h.cnt = q.cnt;
    assign h.cap = q.cap;
    assign h.tmo = q.tmo;
    assign h.cev = q.cev;
    assign h.cmt = q.cmt;
    assign h.pwm = q.pwm;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    chk_one_shot_stop: assert property (
        live && h.run && zero && h.mode == stm_pkg::half_one_shot_mode
        |=> q.st == stm_pkg::HS_DONE && q.tmo)
        else $error("one-shot half did not stop at zero");
    chk_periodic_reload: assert property (
        live && h.run && zero && h.mode == stm_pkg::half_periodic_mode
        |=> q.cnt == $past(h.load) && q.st == stm_pkg::HS_RUN)
        else $error("periodic half did not reload");
    chk_pwm_level: assert property (
        h.mode == stm_pkg::half_pwm_mode && live && q.cnt > h.match
        |=> h.pwm == !$past(h.pol))
        else $error("pwm active level wrong");
    chk_debug_hold: assert property (
        live && !h.run |=> q.cnt == $past(q.cnt))
        else $error("half counted while halted");
    chk_capture_time: assert property (
        live && h.run && h.pin_edge
        && h.mode == stm_pkg::edge_time_capture_mode
        |=> q.cev && q.cap == $past(q.cnt))
        else $error("edge time not captured");
endmodule

// ### stm_top_tb.sv
// split timer: self-checking testbench of the register-level behaviour
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module stm_top_tb;
    // ****************************************
    // signals and instance
    // ****************************************
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, dbg_halt = 1'b0;
    logic        rtc_clk_in = 1'b0, ccp_a_i = 1'b0, ccp_b_i = 1'b0;
    logic [31:0] reg_rdata, v, w;
    logic        ccp_a_o, ccp_a_oe, ccp_b_o, ccp_b_oe, trig_a, trig_b, irq;
    int          n_fail = 0, cmp_count = 0, ta = 0, tb = 0;
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        ta <= ta + int'(trig_a === 1'b1);
        tb <= tb + int'(trig_b === 1'b1);
    end
    stm_top #(.RTC_DIV(4)) stm_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dbg_halt(dbg_halt),
        .rtc_clk_in(rtc_clk_in), .ccp_a_i(ccp_a_i), .ccp_a_o(ccp_a_o),
        .ccp_a_oe(ccp_a_oe), .ccp_b_i(ccp_b_i), .ccp_b_o(ccp_b_o),
        .ccp_b_oe(ccp_b_oe), .trig_a(trig_a), .trig_b(trig_b), .irq(irq));
    // ****************************************
    // bus and helper tasks
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic pulse(input int pin);
        @(posedge sys_clk);
        if (pin == 0) ccp_a_i <= 1'b1; else ccp_b_i <= 1'b1;
        cyc(4);
        ccp_a_i <= 1'b0; ccp_b_i <= 1'b0;
        cyc(4);
    endtask
    task automatic wait_irq();
        for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge sys_clk);
        #1;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_wide();
        wr(stm_pkg::A_LOAD_A, 32'h5); wr(stm_pkg::A_LOAD_B, 32'h0);
        wr(stm_pkg::A_CFG, 32'(stm_pkg::wide_one_shot_mode));
        wr(stm_pkg::A_IEN, 32'h1); wr(stm_pkg::A_CTL, 32'h1);
        wait_irq(); `CHK(irq, 1'b1)
        cyc(10); rd(stm_pkg::A_VAL_A, v); `CHK(v, 32'h0)
        wr(stm_pkg::A_ICLR, 32'h1); cyc(20); `CHK(irq, 1'b0)
        wr(stm_pkg::A_CFG, 32'(stm_pkg::wide_periodic_mode));
        wr(stm_pkg::A_CTL, 32'h1); wait_irq();
        wr(stm_pkg::A_ICLR, 32'h1); cyc(2); wait_irq();
        `CHK(irq, 1'b1)
        wr(stm_pkg::A_CFG, 32'(stm_pkg::wide_periodic_mode));
        rd(stm_pkg::A_CTL, v); `CHK(v[1:0], 2'b00)
        wr(stm_pkg::A_ICLR, 32'h7F); cyc(20); `CHK(irq, 1'b0)
    endtask
    task automatic t_split();
        wr(stm_pkg::A_CFG, 32'h4 | (32'h1 << stm_pkg::CFG_A_LSB));
        wr(stm_pkg::A_LOAD_A, 32'h6); wr(stm_pkg::A_LOAD_B, 32'h3);
        ta = 0; tb = 0;
        wr(stm_pkg::A_CTL, 32'h3 | (32'h1 << stm_pkg::trigger_out_enable_lsb));
        cyc(40); wr(stm_pkg::A_CTL, 32'h0); cyc(4);
        `CHK(ta >= 2, 1'b1)
        `CHK(tb, 0)
        rd(stm_pkg::A_RIS, v); `CHK(v, 32'h11)
        wr(stm_pkg::A_ICLR, 32'h1); rd(stm_pkg::A_RIS, v);
        `CHK(v, 32'h10)
        wr(stm_pkg::A_IEN, 32'h10); rd(stm_pkg::A_MIS, v);
        `CHK(v, 32'h10)
        `CHK(irq, 1'b1)
        wr(stm_pkg::A_IDIS, 32'h10); rd(stm_pkg::A_IEN, v);
        `CHK(v, 32'h1)
        rd(stm_pkg::A_MIS, v); `CHK(v, 32'h0)
        `CHK(irq, 1'b0)
        wr(stm_pkg::A_ICLR, 32'h7F); wr(stm_pkg::A_IDIS, 32'h7F);
    endtask
    task automatic t_debug();
        wr(stm_pkg::A_CFG, 32'h4 | (32'h1 << stm_pkg::CFG_A_LSB));
        wr(stm_pkg::A_LOAD_A, 32'hFFFF); dbg_halt <= 1'b1;
        wr(stm_pkg::A_CTL, 32'h1 | (32'h1 << stm_pkg::debug_halt_select_lsb));
        cyc(4); rd(stm_pkg::A_VAL_A, v); rd(stm_pkg::A_VAL_A, w);
        `CHK(v, w)
        `CHK(w, 32'h0000_FFFF)
        wr(stm_pkg::A_CTL, 32'h1); rd(stm_pkg::A_VAL_A, v);
        rd(stm_pkg::A_VAL_A, w); `CHK(v !== w, 1'b1)
        dbg_halt <= 1'b0; wr(stm_pkg::A_CTL, 32'h0);
    endtask
    task automatic t_pwm();
        wr(stm_pkg::A_CFG, 32'h4 | (32'h4 << stm_pkg::CFG_A_LSB)
           | (32'h4 << stm_pkg::CFG_B_LSB));
        wr(stm_pkg::A_LOAD_A, 32'h8); wr(stm_pkg::A_MATCH_A, 32'hFFFF);
        wr(stm_pkg::A_LOAD_B, 32'h8); wr(stm_pkg::A_MATCH_B, 32'hFFFF);
        wr(stm_pkg::A_CTL, 32'h3 | (32'h2 << stm_pkg::CTL_POL_LSB)); cyc(6);
        `CHK({ccp_a_oe, ccp_b_oe}, 2'b11)
        `CHK({ccp_a_o, ccp_b_o}, 2'b01)
        wr(stm_pkg::A_CTL, 32'h3 | (32'h1 << stm_pkg::CTL_POL_LSB)); cyc(6);
        `CHK({ccp_a_o, ccp_b_o}, 2'b10)
        wr(stm_pkg::A_CTL, 32'h0); wr(stm_pkg::A_MATCH_A, 32'h0);
        wr(stm_pkg::A_MATCH_B, 32'h0); dbg_halt <= 1'b1;
        wr(stm_pkg::A_CTL, 32'h3 | (32'h2 << stm_pkg::CTL_POL_LSB)
           | (32'h3 << stm_pkg::debug_halt_select_lsb)); cyc(4);
        `CHK({ccp_a_o, ccp_b_o}, 2'b10)
        dbg_halt <= 1'b0;
        wr(stm_pkg::A_CTL, 32'h0);
    endtask
    task automatic t_capture();
        wr(stm_pkg::A_CFG, 32'h4 | (32'h2 << stm_pkg::CFG_A_LSB)
           | (32'h3 << stm_pkg::CFG_B_LSB));
        wr(stm_pkg::A_LOAD_A, 32'h2); wr(stm_pkg::A_MATCH_A, 32'h0);
        wr(stm_pkg::A_LOAD_B, 32'hFFFF); wr(stm_pkg::A_CTL, 32'h3);
        pulse(0); pulse(0); rd(stm_pkg::A_RIS, v);
        `CHK(v[stm_pkg::IRQ_CMT], 1'b0)
        pulse(0); pulse(1); rd(stm_pkg::A_RIS, v);
        `CHK(v[stm_pkg::IRQ_CMT], 1'b1)
        `CHK(v[stm_pkg::IRQ_CEV + stm_pkg::IRQ_STEP], 1'b1)
        wr(stm_pkg::A_CTL, 32'h0); wr(stm_pkg::A_ICLR, 32'h7F);
    endtask
    task automatic t_rtc();
        wr(stm_pkg::A_CFG, 32'(stm_pkg::wide_rtc_mode));
        wr(stm_pkg::A_MATCH_A, 32'h1); wr(stm_pkg::A_MATCH_B, 32'h0);
        wr(stm_pkg::A_CTL, 32'h1);
        repeat (12) begin
            cyc(4); rtc_clk_in <= 1'b1; cyc(4); rtc_clk_in <= 1'b0;
        end
        cyc(8); rd(stm_pkg::A_RIS, v);
        `CHK(v[stm_pkg::IRQ_RTC], 1'b1)
    endtask
    // ****************************************
    // sequence, watchdog, verdict
    // ****************************************
    task automatic wrap_up();
        if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        cyc(20); sys_rst <= 1'b0; cyc(1);
        rd(stm_pkg::A_CTL, v); `CHK(v, 32'h0)
        `CHK(irq, 1'b0)
        t_wide(); t_split(); t_debug(); t_pwm(); t_capture(); t_rtc();
        wrap_up();
    end
    initial begin
        #40000;
        n_fail++;
        wrap_up();
    end
endmodule
